// ===== shared/silo_pkg.sv
/*
 * Constants for the multi-line receive silo data path: register offsets,
 * field positions, reset values, select codes and silo geometry.
 * Assumes a 32-bit Avalon-MM slave with byte addresses in four bits.
 */
package silo_pkg;

   // silo geometry
   localparam int         SILO_DEPTH   = 64;
   localparam int         PTR_W        = 6;
   localparam int         CNT_W        = 7;
   localparam int         WORD_W       = 15;
   localparam int         CHAR_W       = 8;
   localparam int         LINE_W       = 4;
   localparam int         STAT_W       = 3;
   localparam int         LINES        = 16;
   localparam int         ADDR_W       = 4;
   localparam int         DATA_W       = 32;
   localparam logic [6:0] FULL_COUNT   = 7'h40;

   // silo word layout, bit 15 is produced on read
   localparam int         CHAR_LSB     = 0;
   localparam int         LINE_LSB     = 8;
   localparam int         STAT_LSB     = 12;
   localparam int         VALID_BIT    = 15;

   // input multiplexer select codes
   localparam logic [1:0]  MUX_NORMAL    = 2'h1;
   localparam logic [1:0]  MUX_MAINT     = 2'h3;
   localparam logic [14:0] MAINT_PATTERN = 15'h5555;

   // register byte offsets
   localparam logic [3:0] ADDR_SILO    = 4'h0;
   localparam logic [3:0] ADDR_CTRL    = 4'h4;
   localparam logic [3:0] ADDR_STATUS  = 4'h8;
   localparam logic [3:0] ADDR_TXBUF   = 4'hc;

   // control register fields
   localparam int         CTRL_MUX_LSB = 0;
   localparam int         CTRL_THR_LSB = 2;
   localparam int         CTRL_CLR_BIT = 4;
   localparam logic [1:0] MUX_RESET    = 2'h1;
   localparam logic [1:0] THR_RESET    = 2'h0;

   // wired character-available thresholds
   localparam logic [6:0] THR_1        = 7'h01;
   localparam logic [6:0] THR_5        = 7'h05;
   localparam logic [6:0] THR_9        = 7'h09;
   localparam logic [6:0] THR_17       = 7'h11;

   // status register fields
   localparam int         ST_CNT_LSB   = 0;
   localparam int         ST_IN_RDY    = 7;
   localparam int         ST_OUT_RDY   = 8;
   localparam int         ST_CHAR_AV   = 9;
   localparam int         ST_LINE_DA   = 10;
   localparam int         ST_TX_EMPTY  = 11;

   localparam logic [7:0] TXBUF_RESET  = 8'h00;

endpackage

// ===== verilog/line_decoder.sv
/*
 * One-of-eight line decoder with an enable, used for each group of
 * eight UARTs on a card.
 * Assumes the caller supplies the enable already qualified by the
 * polarity of the line number's top bit.
 */
`timescale 1ns/1ps

module line_decoder
(
   input  wire logic [2:0] sel,   // low three bits of the line number
   input  wire logic       en,    // group enable
   output logic      [7:0] y      // one-hot select, zero when disabled
);

   always_comb
   begin
      y = 8'h00;
      if (en)
      begin
         y = 8'h01 << sel;
      end
   end

endmodule

// ===== verilog/rx_silo_datapath.sv
/*
 * Receive silo data path of a 16-line serial multiplexer: input word
 * multiplexer, 64-word silo with flags and occupancy count, per-UART
 * select decoding for receive and transmit, and an Avalon-MM slave.
 * Assumes the receive and transmit scanners supply line numbers and
 * request pulses synchronous to clk_sys, and the UART bank resolves
 * its own tri-state character bus from the active-low enables.
 */
`timescale 1ns/1ps

module rx_silo_datapath
(
   input  wire logic        clk_sys,               // system clock, 250 MHz
   input  wire logic        nrst,                  // async reset, active low
   input  wire logic        ce,                    // clock enable, freezes all
   input  wire logic [3:0]  address,               // avalon byte address
   input  wire logic        read,                  // avalon read
   input  wire logic        write,                 // avalon write
   input  wire logic [31:0] writedata,             // avalon write data
   output logic      [31:0] readdata,              // avalon read data
   output logic             waitrequest,           // avalon wait
   input  wire logic [3:0]  receive_line_number,   // receive scan line
   input  wire logic        load_strobe,           // scanner load pulse
   input  wire logic        rx_read_req,           // enable selected UART
   input  wire logic        rx_da_reset_req,       // reset selected DA
   input  wire logic [7:0]  uart_card_low_char,    // lines 0-7 char bus
   input  wire logic [7:0]  uart_card_high_char,   // lines 8-15 char bus
   input  wire logic [2:0]  card_low_status,       // lines 0-7 status
   input  wire logic [2:0]  card_high_status,      // lines 8-15 status
   input  wire logic [15:0] uart_data_available,   // per-UART DA
   input  wire logic [3:0]  tx_line_number,        // transmit scan line
   input  wire logic        tx_strobe_req,         // transmit strobe pulse
   input  wire logic [15:0] uart_tx_empty,         // per-UART tx empty
   output logic      [15:0] uart_rx_enable_n,      // read enable, low drives
   output logic      [15:0] uart_rx_da_reset,      // DA reset per UART
   output logic      [15:0] uart_tx_strobe,        // tx data strobe per UART
   output logic      [7:0]  uart_tx_data,          // tx character to UARTs
   output logic             selected_line_has_char,// DA of receive line
   output logic             selected_tx_empty,     // tx empty of tx line
   output logic             input_ready,           // silo can take a word
   output logic             output_ready,          // silo holds a word
   output logic             char_available         // count at threshold
);

   logic [14:0] mem [silo_pkg::SILO_DEPTH];
   logic [5:0]  wr_ptr;
   logic [5:0]  rd_ptr;
   logic [6:0]  count;
   logic [5:0]  next_wr;
   logic [5:0]  next_rd;
   logic [6:0]  next_count;
   logic        phase;
   logic        ld_pend;
   logic        rd_pend;
   logic        ld_do;
   logic        rd_do;
   logic        rd_pop;
   logic        flag_clear;
   logic [1:0]  mux_sel;
   logic [1:0]  thr_sel;
   logic [14:0] in_word;
   logic [7:0]  rx_char;
   logic [2:0]  card_status;
   logic        line_msb;
   logic        bus_idle;
   logic [7:0]  rx_en_lo;
   logic [7:0]  rx_en_hi;
   logic [7:0]  da_lo;
   logic [7:0]  da_hi;
   logic [7:0]  tx_lo;
   logic [7:0]  tx_hi;

   function automatic logic [6:0] thr_count(input logic [1:0] code);
      logic [6:0] t;
      t = silo_pkg::THR_1;
      case (code)
         2'h1:    t = silo_pkg::THR_5;
         2'h2:    t = silo_pkg::THR_9;
         2'h3:    t = silo_pkg::THR_17;
         default: t = silo_pkg::THR_1;
      endcase
      return t;
   endfunction

   assign line_msb = receive_line_number[3];
   // a request is new only while no answer stands and no silo read waits
   assign bus_idle = waitrequest && !rd_pend;

   // input word multiplexer
   always_comb
   begin
      rx_char     = (~uart_card_low_char & {8{~line_msb}})
                  | (~uart_card_high_char & {8{line_msb}});
      card_status = line_msb ? card_high_status : card_low_status;
      in_word     = 15'h0000;
      case (mux_sel)
         silo_pkg::MUX_NORMAL:
            in_word = {card_status, receive_line_number, rx_char};
         silo_pkg::MUX_MAINT:
            in_word = silo_pkg::MAINT_PATTERN;
         default:
            in_word = 15'h0000;
      endcase
   end

   // loads on the even phase, reads on the odd one, so they never meet
   assign ld_do  = ce && ld_pend && !phase && input_ready;
   assign rd_do  = ce && rd_pend && phase && !flag_clear;
   assign rd_pop = rd_do && output_ready;

   always_comb
   begin
      next_wr    = wr_ptr;
      next_rd    = rd_ptr;
      next_count = count;
      if (flag_clear)
      begin
         next_rd    = wr_ptr;
         next_count = 7'h00;
      end
      if (ld_do)
      begin
         next_wr    = wr_ptr + 6'h01;
         next_count = next_count + 7'h01;
      end
      else if (rd_pop)
      begin
         next_rd    = rd_ptr + 6'h01;
         next_count = count - 7'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         phase <= 1'b0;
      end
      else if (ce)
      begin
         phase <= !phase;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         ld_pend <= 1'b0;
      end
      else if (ce)
      begin
         // a strobe while full is dropped; the scanner waits on input_ready
         if (load_strobe)
         begin
            ld_pend <= 1'b1;
         end
         else if (!phase)
         begin
            ld_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (ld_do)
      begin
         mem[wr_ptr] <= in_word;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_ptr         <= 6'h00;
         rd_ptr         <= 6'h00;
         count          <= 7'h00;
         input_ready    <= 1'b1;
         output_ready   <= 1'b0;
         char_available <= 1'b0;
      end
      else if (ce)
      begin
         wr_ptr         <= next_wr;
         rd_ptr         <= next_rd;
         count          <= next_count;
         input_ready    <= next_count != silo_pkg::FULL_COUNT;
         output_ready   <= next_count != 7'h00;
         char_available <= next_count == thr_count(thr_sel);
      end
   end

   // bus slave: waitrequest low for exactly one cycle per access
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         waitrequest <= 1'b1;
         rd_pend     <= 1'b0;
         readdata    <= 32'h00000000;
      end
      else if (ce)
      begin
         waitrequest <= 1'b1;
         if (rd_do)
         begin
            rd_pend     <= 1'b0;
            waitrequest <= 1'b0;
            readdata    <= {16'h0000, output_ready, mem[rd_ptr]};
         end
         else if (bus_idle && read)
         begin
            if (address == silo_pkg::ADDR_SILO)
            begin
               rd_pend <= 1'b1;
            end
            else if (address == silo_pkg::ADDR_CTRL)
            begin
               waitrequest <= 1'b0;
               readdata    <= {28'h0000000, thr_sel, mux_sel};
            end
            else if (address == silo_pkg::ADDR_STATUS)
            begin
               waitrequest <= 1'b0;
               readdata    <= {20'h00000, selected_tx_empty, selected_line_has_char,
                               char_available, output_ready, input_ready, count};
            end
            else if (address == silo_pkg::ADDR_TXBUF)
            begin
               waitrequest <= 1'b0;
               readdata    <= {24'h000000, uart_tx_data};
            end
            else
            begin
               waitrequest <= 1'b0;
               readdata    <= 32'h00000000;
            end
         end
         else if (bus_idle && write)
         begin
            waitrequest <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         mux_sel      <= silo_pkg::MUX_RESET;
         thr_sel      <= silo_pkg::THR_RESET;
         flag_clear   <= 1'b0;
         uart_tx_data <= silo_pkg::TXBUF_RESET;
      end
      else if (ce)
      begin
         flag_clear <= 1'b0;
         // a write lands only at the edge where the master sees the answer
         if (!waitrequest && write && !read)
         begin
            if (address == silo_pkg::ADDR_CTRL)
            begin
               mux_sel    <= writedata[silo_pkg::CTRL_MUX_LSB +: 2];
               thr_sel    <= writedata[silo_pkg::CTRL_THR_LSB +: 2];
               flag_clear <= writedata[silo_pkg::CTRL_CLR_BIT];
            end
            else if (address == silo_pkg::ADDR_TXBUF)
            begin
               uart_tx_data <= writedata[7:0];
            end
         end
      end
   end

   // per-card decoders, top bit gates the two groups in opposite sense
   line_decoder u_rx_en_lo (.sel(receive_line_number[2:0]),
                            .en(rx_read_req && !line_msb), .y(rx_en_lo));
   line_decoder u_rx_en_hi (.sel(receive_line_number[2:0]),
                            .en(rx_read_req && line_msb), .y(rx_en_hi));
   line_decoder u_da_lo    (.sel(receive_line_number[2:0]),
                            .en(rx_da_reset_req && !line_msb), .y(da_lo));
   line_decoder u_da_hi    (.sel(receive_line_number[2:0]),
                            .en(rx_da_reset_req && line_msb), .y(da_hi));
   line_decoder u_tx_lo    (.sel(tx_line_number[2:0]),
                            .en(tx_strobe_req && !tx_line_number[3]), .y(tx_lo));
   line_decoder u_tx_hi    (.sel(tx_line_number[2:0]),
                            .en(tx_strobe_req && tx_line_number[3]), .y(tx_hi));

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         uart_rx_enable_n <= 16'hffff;
         uart_rx_da_reset <= 16'h0000;
         uart_tx_strobe   <= 16'h0000;
      end
      else if (ce)
      begin
         uart_rx_enable_n <= ~{rx_en_hi, rx_en_lo};
         uart_rx_da_reset <= {da_hi, da_lo};
         uart_tx_strobe   <= {tx_hi, tx_lo};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         selected_line_has_char <= 1'b0;
         selected_tx_empty      <= 1'b0;
      end
      else if (ce)
      begin
         selected_line_has_char <= uart_data_available[receive_line_number];
         selected_tx_empty      <= uart_tx_empty[tx_line_number];
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   chk_no_dual_service: assert property (!(ld_do && rd_do))
      else $error("load and read serviced in one cycle");

   chk_ready_flags: assert property (
      output_ready == (count != 7'h00) && input_ready == (count != 7'h40))
      else $error("ready flags disagree with count");

   chk_valid_bit: assert property (rd_do |=> readdata[15] == $past(output_ready))
      else $error("valid bit not taken from output ready");

   chk_count_up: assert property (ld_do && !flag_clear |=> count == $past(count) + 7'h01)
      else $error("load did not raise count");

   chk_count_down: assert property (rd_pop |=> count == $past(count) - 7'h01)
      else $error("read did not lower count");

   chk_single_driver: assert property ($onehot0(~uart_rx_enable_n))
      else $error("more than one UART enabled");

   chk_rx_enable_sel: assert property (ce && rx_read_req |=>
      uart_rx_enable_n == ~(16'h0001 << $past(receive_line_number)))
      else $error("wrong UART read enable");

   chk_tx_strobe_sel: assert property (ce && tx_strobe_req |=>
      uart_tx_strobe == (16'h0001 << $past(tx_line_number)))
      else $error("wrong UART transmit strobe");

   chk_maint_pattern: assert property (ld_do && mux_sel == 2'h3 |=>
      mem[$past(wr_ptr)] == 15'h5555)
      else $error("maintenance pattern not loaded");

   chk_clear_keeps: assert property (ce && flag_clear && !ld_do |=>
      !output_ready && wr_ptr == $past(wr_ptr) && count == 7'h00)
      else $error("flag clear misbehaved");

endmodule

// ===== bench/uart_bank_model.sv
/*
 * Behavioural bank of sixteen UARTs on two cards, facing the silo data path.
 * Assumes the data path drives active-low read enables and one-hot strobes.
 */
`timescale 1ns/1ps

module uart_bank_model
(
   input  wire logic        clk_sys,             // system clock
   input  wire logic        nrst,                // async reset, active low
   input  wire logic [15:0] uart_rx_enable_n,    // read enables, low drives
   input  wire logic [15:0] uart_rx_da_reset,    // DA reset per UART
   input  wire logic [15:0] uart_tx_strobe,      // tx strobe per UART
   input  wire logic [7:0]  uart_tx_data,        // tx character
   output logic      [7:0]  uart_card_low_char,  // lines 0-7 char bus
   output logic      [7:0]  uart_card_high_char, // lines 8-15 char bus
   output logic      [2:0]  card_low_status,     // lines 0-7 status
   output logic      [2:0]  card_high_status,    // lines 8-15 status
   output logic      [15:0] uart_data_available, // per-UART DA
   output logic      [15:0] uart_tx_empty,       // per-UART tx empty
   output logic      [7:0]  last_tx_char         // last char taken
);
   logic [7:0] idle_pat;
   logic [3:0] bit_div;
   logic [3:0] tx_bits;

   assign card_low_status  = 3'h5;
   assign card_high_status = 3'h2;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         uart_data_available <= 16'hffff;
         uart_tx_empty       <= 16'hffff;
         idle_pat            <= 8'h00;
         last_tx_char        <= 8'h00;
         bit_div             <= 4'h0;
         tx_bits             <= 4'h0;
      end
      else
      begin
         idle_pat            <= idle_pat + 8'h01;
         uart_data_available <= uart_data_available & ~uart_rx_da_reset;
         // a frame is ten bit times of sixteen bit clocks each
         if (tx_bits != 4'h0)
         begin
            bit_div <= bit_div + 4'h1;
            if (bit_div == 4'hf)
            begin
               tx_bits <= tx_bits - 4'h1;
               if (tx_bits == 4'h1)
                  uart_tx_empty <= 16'hffff;
            end
         end
         if (|uart_tx_strobe)
         begin
            tx_bits <= 4'ha;
            bit_div <= 4'h0;
         end
         for (int i = 0; i < 16; i++)
         begin
            if (uart_tx_strobe[i])
            begin
               uart_tx_empty[i] <= 1'b0;
               last_tx_char     <= uart_tx_data;
            end
         end
      end
   end

   // floating bus shows a moving pattern, never the last character
   always_comb
   begin
      uart_card_low_char  = idle_pat;
      uart_card_high_char = ~idle_pat;
      for (int i = 0; i < 16; i++)
      begin
         if (!uart_rx_enable_n[i] && i < 8)
            uart_card_low_char = ~{4'(i), ~4'(i)};
         if (!uart_rx_enable_n[i] && i >= 8)
            uart_card_high_char = ~{4'(i), ~4'(i)};
      end
   end
endmodule

// ===== bench/tb.sv
/*
 * Self-checking bench for the receive silo data path, driving the
 * Avalon-MM registers and the scanner requests by tasks.
 * Assumes the UART bank model in the bench folder.
 */
`timescale 1ns/1ps

module tb;
   logic clk_sys, nrst, read, write, load_strobe, rx_read_req, rx_da_reset_req;
   logic tx_strobe_req, selected_line_has_char, selected_tx_empty, waitrequest;
   logic input_ready, output_ready, char_available;
   logic [3:0] address, receive_line_number, tx_line_number;
   logic [31:0] writedata, readdata, rd;
   logic [7:0] lo_ch, hi_ch, tx_data, last_tx;
   logic [2:0] lo_st, hi_st;
   logic [15:0] da, txe, en_n, da_rst, tx_stb;
   int err_total, n_checks;

   rx_silo_datapath rx_silo_datapath_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest),
      .receive_line_number(receive_line_number), .load_strobe(load_strobe),
      .rx_read_req(rx_read_req), .rx_da_reset_req(rx_da_reset_req),
      .uart_card_low_char(lo_ch), .uart_card_high_char(hi_ch),
      .card_low_status(lo_st), .card_high_status(hi_st), .uart_data_available(da),
      .tx_line_number(tx_line_number), .tx_strobe_req(tx_strobe_req),
      .uart_tx_empty(txe), .uart_rx_enable_n(en_n), .uart_rx_da_reset(da_rst),
      .uart_tx_strobe(tx_stb), .uart_tx_data(tx_data),
      .selected_line_has_char(selected_line_has_char),
      .selected_tx_empty(selected_tx_empty), .input_ready(input_ready),
      .output_ready(output_ready), .char_available(char_available));

   uart_bank_model uart_bank_model_inst (.clk_sys(clk_sys), .nrst(nrst),
      .uart_rx_enable_n(en_n), .uart_rx_da_reset(da_rst), .uart_tx_strobe(tx_stb),
      .uart_tx_data(tx_data), .uart_card_low_char(lo_ch), .uart_card_high_char(hi_ch),
      .card_low_status(lo_st), .card_high_status(hi_st), .uart_data_available(da),
      .uart_tx_empty(txe), .last_tx_char(last_tx));

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one access; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      read      <= ~wr;
      write     <= wr;
      address   <= a;
      writedata <= d;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk_sys);
         if (waitrequest === 1'b0)
            break;
      end
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      if (n == 40)
      begin
         err_total++;
         complete_run();
      end
   endtask

   // scanner sequence: enable the line's UART, strobe the load, release
   task automatic load_line(input logic [3:0] ln);
      @(posedge clk_sys);
      receive_line_number <= ln;
      rx_read_req         <= 1'b1;
      repeat (2) @(posedge clk_sys);
      load_strobe <= 1'b1;
      @(posedge clk_sys);
      load_strobe <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rx_read_req <= 1'b0;
      @(posedge clk_sys);
   endtask

   function automatic logic [31:0] word_of(input logic [3:0] ln);
      return {16'h0, 1'b1, ln[3] ? 3'h2 : 3'h5, ln, ln, ~ln};
   endfunction

   // kind 0 read enable, 1 data-available reset, 2 transmit strobe
   task automatic pulse_check(input string nm, input int kind, input logic [3:0] ln,
                              input logic [15:0] exp);
      @(posedge clk_sys);
      receive_line_number <= ln;
      tx_line_number      <= ln;
      rx_read_req         <= (kind == 0);
      rx_da_reset_req     <= (kind == 1);
      tx_strobe_req       <= (kind == 2);
      @(posedge clk_sys);
      #1 chk(nm, {16'h0, exp}, {16'h0, kind == 0 ? en_n : kind == 1 ? da_rst : tx_stb});
      @(posedge clk_sys);
      {rx_read_req, rx_da_reset_req, tx_strobe_req} <= 3'h0;
   endtask

   logic [3:0] seq [4] = '{4'h3, 4'h9, 4'hc, 4'h0};

   initial
   begin
      err_total = 0;
      n_checks  = 0;
      {nrst, read, write, load_strobe, rx_read_req, rx_da_reset_req} = 6'h00;
      {tx_strobe_req, address, writedata} = 37'h0;
      {receive_line_number, tx_line_number} = 8'h00;
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      bus(1'b0, 4'h8, 32'h0);   chk("status_rst", 32'hc80, rd & 32'hfff);
      bus(1'b0, 4'h4, 32'h0);   chk("ctrl_rst", 32'h1, rd);
      bus(1'b0, 4'h0, 32'h0);   chk("empty_valid", 32'h0, rd & 32'h8000);
      bus(1'b0, 4'h2, 32'h0);   chk("unmapped", 32'h0, rd);
      foreach (seq[i]) load_line(seq[i]);
      bus(1'b0, 4'h8, 32'h0);   chk("count4", 32'h184, rd & 32'h1ff);
      foreach (seq[i])
      begin
         bus(1'b0, 4'h0, 32'h0);   chk("silo_word", word_of(seq[i]), rd);
      end
      bus(1'b0, 4'h0, 32'h0);   chk("drained", 32'h0, rd & 32'h8000);
      pulse_check("rx_enable", 0, 4'h9, ~16'h0200);
      pulse_check("rx_enable_lo", 0, 4'h6, ~16'h0040);
      pulse_check("da_reset", 1, 4'h3, 16'h0008);
      repeat (2) @(posedge clk_sys);
      #1 chk("line_da3", 32'h0, {31'h0, selected_line_has_char});
      bus(1'b1, 4'h4, 32'h5);
      for (int i = 1; i <= 6; i++)
      begin
         load_line(4'(i));
         #1 chk("char_av", {31'h0, i == 5}, {31'h0, char_available});
      end
      for (int i = 6; i < 64; i++) load_line(4'(i));
      #1 chk("in_rdy_full", 32'h0, {31'h0, input_ready});
      load_line(4'h7);
      bus(1'b0, 4'h8, 32'h0);   chk("full_count", 32'h140, rd & 32'h1ff);
      bus(1'b1, 4'h4, 32'h11);
      bus(1'b0, 4'h8, 32'h0);   chk("clr_count", 32'h080, rd & 32'h1ff);
      bus(1'b0, 4'h0, 32'h0);   chk("clr_valid", 32'h0, rd & 32'h8000);
      load_line(4'ha);
      bus(1'b0, 4'h0, 32'h0);   chk("after_clr", word_of(4'ha), rd);
      bus(1'b1, 4'h4, 32'h3);
      load_line(4'h2);
      bus(1'b0, 4'h0, 32'h0);   chk("pattern", 32'hd555, rd);
      bus(1'b1, 4'h4, 32'h1);
      bus(1'b1, 4'hc, 32'ha5);
      bus(1'b0, 4'hc, 32'h0);   chk("txbuf", 32'ha5, rd);
      chk("tx_data", 32'ha5, {24'h0, tx_data});
      pulse_check("tx_strobe", 2, 4'hd, 16'h2000);
      repeat (3) @(posedge clk_sys);
      #1 chk("tx_empty13", 32'h0, {31'h0, selected_tx_empty});
      chk("tx_char", 32'ha5, {24'h0, last_tx});
      @(posedge clk_sys);
      tx_line_number <= 4'h2;
      repeat (2) @(posedge clk_sys);
      #1 chk("tx_empty2", 32'h1, {31'h0, selected_tx_empty});
      load_line(4'h1);
      @(posedge clk_sys);
      nrst <= 1'b0;
      @(posedge clk_sys);
      #1 chk("rst_out_rdy", 32'h2, {30'h0, input_ready, output_ready});
      @(posedge clk_sys);
      nrst <= 1'b1;
      bus(1'b0, 4'h0, 32'h0);   chk("rst_empty", 32'h0, rd & 32'h8000);
      complete_run();
   end
endmodule
